// >>> rtl/smt_pkg.sv
// Constants and types for the sixteen-bit multimode timer
package smt_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Mode select encodings
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_EXT_TRIG = 3'h1;
    localparam logic [2:0] MODE_EVENT = 3'h2;
    localparam logic [2:0] MODE_WINDOW = 3'h3;
    localparam logic [2:0] MODE_PWM = 3'h6;
    localparam logic [2:0] MODE_PPG = 3'h7;
    // Source clock select encodings
    localparam logic [1:0] SRC_DIV3 = 2'h0;
    localparam logic [1:0] SRC_DIV7 = 2'h1;
    localparam logic [1:0] SRC_DIV11 = 2'h2;
    // Start select encodings
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_CMD = 2'h1;
    localparam logic [1:0] START_EXT = 2'h2;
    // Prescaler tap positions
    localparam int TAP_FC3 = 2;
    localparam int TAP_FC7 = 6;
    localparam int TAP_FC11 = 10;
    localparam int TAP_FS3 = 2;
    localparam int FC_DIV_W = 11;
    localparam int FS_DIV_W = 3;
    // Noise filter: pulses of 7 fc cycles or less are rejected
    localparam logic [3:0] FILT_REJECT = 4'h7;
    localparam logic [3:0] FILT_FULL = 4'h8;
    typedef enum logic [2:0] {
        SMT_IDLE = 3'b001,
        SMT_RUN = 3'b010,
        SMT_HALT = 3'b100
    } smt_state_t;
endpackage

// >>> rtl/smt_timer.sv
// Sixteen-bit multimode timer/counter with pulse generator output
//
// Behaviour
// - Timer mode counts internal clock, matches period, interrupts, clears, continues.
// - Soft capture request copies count to capture register, then self-clears.
// - Source clock is a prescaler tap; slow mode offers only fs/8.
// - External trigger mode starts on edge, halts cleared after period match.
// - Count pin filtered against 7/fc pulses, filter bypassed in slow mode.
// - Event counter counts selected pin edges, interrupts and clears on match.
// - Window mode counts internal clock gated by pin of selected polarity.
// - Pulse width mode starts on trigger edge, captures on opposite edge.
// - Single-edge capture clears counter; double-edge also captures next trigger edge.
// - Pulse width capture with fc/8 source reads LSB as zero.
// - Pulse generator starts on edge or command; compare match toggles output.
// - Period match toggles output again, clears counter, raises interrupt.
// - Output flip-flop resets to zero and software can preset it.
// - Capture register writes accepted only in pulse generator mode.
// - Reset leaves period and capture registers unchanged.
// - Trigger edge select comes from external interrupt control bit 3.
`timescale 1ns/10ps
`default_nettype none
module smt_timer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic fs_tick_in,
    input wire logic slow_mode_in,
    input wire logic ctrl_wr_in,
    input wire logic [2:0] mode_select_in,
    input wire logic [1:0] source_clock_select_in,
    input wire logic [1:0] start_select_in,
    input wire logic soft_capture_req_in,
    input wire logic capture_edge_count_sel_in,
    input wire logic flipflop_init_value_in,
    input wire logic prescaler_tap_select_in,
    input wire logic trigger_edge_select_in,
    input wire logic period_wr_in,
    input wire logic [15:0] period_data_in,
    input wire logic capcmp_wr_in,
    input wire logic [15:0] capcmp_data_in,
    input wire logic count_input_pin_in,
    output logic [15:0] capture_compare_reg_out,
    output logic [15:0] count_out,
    output logic match_interrupt_out,
    output logic pulse_generator_output_out
);
    logic [2:0] mode_reg;
    logic [1:0] src_reg;
    logic [1:0] start_reg;
    logic dbl_reg;
    logic [15:0] period_match_reg;
    logic [15:0] capture_compare_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic ffo_reg;
    logic irq_reg;
    logic [10:0] fc_div_reg;
    logic [2:0] fs_div_reg;
    logic tap_reg;
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic [3:0] filt_cnt_reg;
    logic filt_reg;
    logic filt_d_reg;
    smt_pkg::smt_state_t state_reg;
    smt_pkg::smt_state_t state_next;

    // Internal tap: fc side free-runs, fs side advances on fs ticks
    wire [10:0] fc_div_next = fc_div_reg + 11'h001;
    wire [2:0] fs_div_next = fs_div_reg + 3'h1;
    wire fs_tap = fs_div_reg[smt_pkg::TAP_FS3];
    wire tap_sel = slow_mode_in ? fs_tap :
        (src_reg == smt_pkg::SRC_DIV3) ? fc_div_reg[smt_pkg::TAP_FC3] :
        (src_reg == smt_pkg::SRC_DIV7) ? fc_div_reg[smt_pkg::TAP_FC7] :
        prescaler_tap_select_in ? fs_tap : fc_div_reg[smt_pkg::TAP_FC11];
    wire win_level = filt_reg ^ ~trigger_edge_select_in;
    wire tap_gated = tap_sel & ((mode_reg != smt_pkg::MODE_WINDOW) | win_level);
    wire tick = tap_gated & ~tap_reg;

    // Noise filter output edges; polarity follows the edge select bit
    wire pin_rise = filt_reg & ~filt_d_reg;
    wire pin_fall = ~filt_reg & filt_d_reg;
    wire trig_edge = trigger_edge_select_in ? pin_rise : pin_fall;
    wire opp_edge = trigger_edge_select_in ? pin_fall : pin_rise;

    wire is_timer = mode_reg == smt_pkg::MODE_TIMER;
    wire is_ext = mode_reg == smt_pkg::MODE_EXT_TRIG;
    wire is_event = mode_reg == smt_pkg::MODE_EVENT;
    wire is_pwm = mode_reg == smt_pkg::MODE_PWM;
    wire is_ppg = mode_reg == smt_pkg::MODE_PPG;
    wire running = state_reg == smt_pkg::SMT_RUN;
    wire adv = running & (is_event ? trig_edge : tick);
    wire period_hit = adv & ~is_pwm & (cnt_reg + smt_pkg::CNT_ONE == period_match_reg);
    wire cmp_hit = adv & is_ppg & (cnt_reg + smt_pkg::CNT_ONE == capture_compare_reg);
    wire pwm_cap = running & is_pwm & (opp_edge | (dbl_reg & trig_edge));
    wire pwm_clr = pwm_cap & ~dbl_reg;
    wire fc3_src = ~slow_mode_in & (src_reg == smt_pkg::SRC_DIV3);
    wire [15:0] pwm_val = fc3_src ? {cnt_reg[15:1], 1'b0} : cnt_reg;
    wire soft_cap = ctrl_wr_in & soft_capture_req_in;
    wire start_ext = start_reg == smt_pkg::START_EXT;
    wire start_cmd = start_reg == smt_pkg::START_CMD;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            smt_pkg::SMT_IDLE: begin
                if (start_cmd & ~is_pwm & ~is_ext) begin
                    state_next = smt_pkg::SMT_RUN;
                end else if (start_ext & trig_edge) begin
                    state_next = smt_pkg::SMT_RUN;
                end
            end
            smt_pkg::SMT_RUN: begin
                if (start_reg == smt_pkg::START_STOP) begin
                    state_next = smt_pkg::SMT_IDLE;
                end else if (period_hit & (is_ext | (is_ppg & start_ext))) begin
                    state_next = smt_pkg::SMT_HALT;
                end
            end
            smt_pkg::SMT_HALT: begin
                if (start_reg == smt_pkg::START_STOP) begin
                    state_next = smt_pkg::SMT_IDLE;
                end else if (trig_edge) begin
                    state_next = smt_pkg::SMT_RUN;
                end
            end
            default: state_next = smt_pkg::SMT_IDLE;
        endcase
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (!running) begin
            cnt_next = smt_pkg::CNT_ZERO;
        end else if (period_hit | pwm_clr) begin
            cnt_next = smt_pkg::CNT_ZERO;
        end else if (adv) begin
            cnt_next = cnt_reg + smt_pkg::CNT_ONE;
        end
    end

    // Prescaler and pin path
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fc_div_reg <= 11'h000;
            fs_div_reg <= 3'h0;
            tap_reg <= 1'b0;
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            filt_cnt_reg <= 4'h0;
            filt_reg <= 1'b0;
            filt_d_reg <= 1'b0;
        end else if (ce_in) begin
            fc_div_reg <= fc_div_next;
            if (fs_tick_in) begin
                fs_div_reg <= fs_div_next;
            end
            tap_reg <= tap_gated;
            pin_s1_reg <= count_input_pin_in;
            pin_s2_reg <= pin_s1_reg;
            filt_d_reg <= filt_reg;
            if (slow_mode_in | (pin_s2_reg == filt_reg)) begin
                filt_cnt_reg <= 4'h0;
            end else if (filt_cnt_reg != smt_pkg::FILT_FULL) begin
                filt_cnt_reg <= filt_cnt_reg + 4'h1;
            end
            if (slow_mode_in) begin
                filt_reg <= pin_s2_reg;
            end else if (filt_cnt_reg == smt_pkg::FILT_REJECT) begin
                filt_reg <= pin_s2_reg;
            end
        end
    end

    // Control, counter and output flip-flop
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_reg <= smt_pkg::MODE_TIMER;
            src_reg <= smt_pkg::SRC_DIV3;
            start_reg <= smt_pkg::START_STOP;
            dbl_reg <= 1'b0;
            cnt_reg <= smt_pkg::CNT_ZERO;
            ffo_reg <= 1'b0;
            irq_reg <= 1'b0;
            state_reg <= smt_pkg::SMT_IDLE;
        end else if (ce_in) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            irq_reg <= period_hit | pwm_cap;
            if (ctrl_wr_in) begin
                mode_reg <= mode_select_in;
                src_reg <= source_clock_select_in;
                start_reg <= start_select_in;
                dbl_reg <= capture_edge_count_sel_in;
                ffo_reg <= flipflop_init_value_in;
            end else if (is_ppg & (cmp_hit | period_hit)) begin
                ffo_reg <= ~ffo_reg;
            end
        end
    end

    // Timer registers have no reset term
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (period_wr_in) begin
                period_match_reg <= period_data_in;
            end
            if (pwm_cap) begin
                capture_compare_reg <= pwm_val;
            end else if (soft_cap) begin
                capture_compare_reg <= cnt_reg;
            end else if (capcmp_wr_in & is_ppg) begin
                capture_compare_reg <= capcmp_data_in;
            end
        end
    end

    assign capture_compare_reg_out = capture_compare_reg;
    assign count_out = cnt_reg;
    assign match_interrupt_out = irq_reg;
    assign pulse_generator_output_out = ffo_reg;

    a_irq_on_match: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && period_hit |=> match_interrupt_out) else $error("no interrupt on match");
    a_irq_single: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && match_interrupt_out && !period_hit && !pwm_cap |=> !match_interrupt_out)
        else $error("irq stretched");
    a_clear_on_match: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && period_hit |=> count_out == 16'h0000) else $error("count not cleared");
    a_soft_capture: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && soft_cap && !pwm_cap |=> capture_compare_reg_out == $past(cnt_reg)) else $error("soft capture lost");
    a_ext_halt: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && running && is_ext && period_hit && start_ext |=> state_reg == smt_pkg::SMT_HALT)
        else $error("ext trigger did not halt");
    a_pwm_lsb: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && pwm_cap && fc3_src |=> !capture_compare_reg_out[0]) else $error("lsb not zero");
    a_ppg_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !ctrl_wr_in && is_ppg && cmp_hit |=> pulse_generator_output_out != $past(ffo_reg))
        else $error("no toggle on compare");
    a_ppg_period: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !ctrl_wr_in && is_ppg && period_hit |=> pulse_generator_output_out != $past(ffo_reg)
        ##0 match_interrupt_out) else $error("no toggle on period");
    a_capcmp_guard: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && capcmp_wr_in && !is_ppg && !pwm_cap && !soft_cap |=> $stable(capture_compare_reg_out))
        else $error("capture register written outside ppg");
    a_single_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && pwm_clr |=> count_out == 16'h0000) else $error("single edge not cleared");
endmodule
`default_nettype wire

// >>> test/smt_pulse_src.sv
// Pulse source model that drives the timer count input pin
`timescale 1ns/10ps
`default_nettype none
module smt_pulse_src (
    input wire logic clk_in,
    output logic pin_out
);
    initial pin_out = 1'b0;
    // High level lasts 24 cycles, low 25 between pulses, so the rate stays well below fc/16
    task automatic pulse(input int n);
        repeat (n) begin
            @(negedge clk_in);
            pin_out = 1'b1;
            repeat (24) @(negedge clk_in);
            pin_out = 1'b0;
            repeat (24) @(negedge clk_in);
        end
    endtask
endmodule
`default_nettype wire

// >>> test/tb_sixteen_bit_multimode_timer.sv
// Self-checking bench for the sixteen-bit multimode timer
`timescale 1ns/10ps
`default_nettype none
module tb_sixteen_bit_multimode_timer;
    logic clk = 1'b0, rst = 1'b1, fs_tick = 1'b0, ctrl_wr = 1'b0, scap = 1'b0, ffi = 1'b0, edge_sel = 1'b1;
    logic period_wr = 1'b0, capcmp_wr = 1'b0, pin, irq, pulse_generator_output, ce = 1'b1, dbl = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] src = 2'h0, start = 2'h0;
    logic [15:0] pdata = 16'h0000, cdata = 16'h0000, capcmp, count;
    int failures = 0, compares = 0, cycles = 0, n;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        fs_tick <= (cycles % 16 == 0);
        if (cycles == 20000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    smt_pulse_src u_src (.clk_in(clk), .pin_out(pin));
    smt_timer u_dut (.clk_in(clk), .rst_in(rst), .ce_in(ce), .fs_tick_in(fs_tick), .slow_mode_in(1'b0),
        .ctrl_wr_in(ctrl_wr), .mode_select_in(mode), .source_clock_select_in(src), .start_select_in(start),
        .soft_capture_req_in(scap), .capture_edge_count_sel_in(dbl), .flipflop_init_value_in(ffi),
        .prescaler_tap_select_in(1'b0), .trigger_edge_select_in(edge_sel), .period_wr_in(period_wr),
        .period_data_in(pdata), .capcmp_wr_in(capcmp_wr), .capcmp_data_in(cdata), .count_input_pin_in(pin),
        .capture_compare_reg_out(capcmp), .count_out(count), .match_interrupt_out(irq),
        .pulse_generator_output_out(pulse_generator_output));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ctrl(input logic [2:0] m, input logic [1:0] s, input logic [1:0] st, input logic c, input logic f);
        @(negedge clk);
        {mode, src, start, scap, ffi, ctrl_wr} = {m, s, st, c, f, 1'b1};
        @(negedge clk);
        {ctrl_wr, scap} = 2'b00;
    endtask
    task automatic wr(input logic which, input logic [15:0] d);
        @(negedge clk);
        {pdata, cdata} = {d, d};
        if (which) capcmp_wr = 1'b1;
        else period_wr = 1'b1;
        @(negedge clk);
        {period_wr, capcmp_wr} = 2'b00;
    endtask
    task automatic wait_irq();
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (irq !== 1'b1 && n < 3000);
    endtask
    task automatic t_timer();
        wr(1'b0, 16'h0004);
        ctrl(smt_pkg::MODE_TIMER, smt_pkg::SRC_DIV3, smt_pkg::START_CMD, 1'b0, 1'b0);
        wait_irq();
        chk(count, smt_pkg::CNT_ZERO);
        wait_irq();
        chk(n, 16'h0020);
        @(negedge clk);
        ce = 1'b0;
        repeat (40) @(negedge clk);
        chk(count, smt_pkg::CNT_ZERO);
        ce = 1'b1;
    endtask
    task automatic t_pwm();
        wr(1'b0, 16'h0100);
        ctrl(smt_pkg::MODE_PWM, smt_pkg::SRC_DIV3, smt_pkg::START_EXT, 1'b0, 1'b0);
        fork
            u_src.pulse(1);
            wait_irq();
        join
        chk({15'h0000, n < 3000}, 16'h0001);
        chk({15'h0000, capcmp[0]}, 16'h0000);
        chk({15'h0000, capcmp != 16'h0000}, 16'h0001);
    endtask
    task automatic t_event();
        wr(1'b0, 16'h0064);
        ctrl(smt_pkg::MODE_EVENT, smt_pkg::SRC_DIV3, smt_pkg::START_CMD, 1'b0, 1'b0);
        u_src.pulse(3);
        chk(count, 16'h0003);
        ctrl(smt_pkg::MODE_EVENT, smt_pkg::SRC_DIV3, smt_pkg::START_CMD, 1'b1, 1'b0);
        @(negedge clk);
        chk(capcmp, 16'h0003);
        wr(1'b1, 16'h1234);
        chk(capcmp, 16'h0003);
        @(negedge clk) rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        chk(capcmp, 16'h0003);
        chk(count, smt_pkg::CNT_ZERO);
        wr(1'b0, 16'h0002);
        ctrl(smt_pkg::MODE_EVENT, smt_pkg::SRC_DIV3, smt_pkg::START_CMD, 1'b0, 1'b0);
        fork
            u_src.pulse(2);
            wait_irq();
        join
        chk(count, smt_pkg::CNT_ZERO);
    endtask
    task automatic t_trigger();
        wr(1'b0, 16'h0003);
        ctrl(smt_pkg::MODE_EXT_TRIG, smt_pkg::SRC_DIV3, smt_pkg::START_EXT, 1'b0, 1'b0);
        chk(count, smt_pkg::CNT_ZERO);
        fork
            u_src.pulse(1);
            wait_irq();
        join
        chk({15'h0000, n < 3000}, 16'h0001);
        repeat (64) @(negedge clk);
        chk(count, smt_pkg::CNT_ZERO);
    endtask
    task automatic t_ppg();
        ctrl(smt_pkg::MODE_PPG, smt_pkg::SRC_DIV3, smt_pkg::START_STOP, 1'b0, 1'b0);
        chk({15'h0000, pulse_generator_output}, 16'h0000);
        wr(1'b1, 16'h0002);
        chk(capcmp, 16'h0002);
        wr(1'b0, 16'h0004);
        ctrl(smt_pkg::MODE_PPG, smt_pkg::SRC_DIV3, smt_pkg::START_CMD, 1'b0, 1'b0);
        n = 0;
        while (pulse_generator_output !== 1'b1 && n < 100) begin
            @(negedge clk);
            n = n + 1;
        end
        chk({15'h0000, pulse_generator_output}, 16'h0001);
        wait_irq();
        chk({15'h0000, pulse_generator_output}, 16'h0000);
        chk(count, smt_pkg::CNT_ZERO);
        ctrl(smt_pkg::MODE_PPG, smt_pkg::SRC_DIV3, smt_pkg::START_STOP, 1'b0, 1'b1);
        chk({15'h0000, pulse_generator_output}, 16'h0001);
    endtask
    task automatic stop_test();
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_timer();
        t_event();
        t_trigger();
        t_ppg();
        t_pwm();
        stop_test();
    end
endmodule
`default_nettype wire
